/* include/rftm_pkg.sv */
// Package for the reset-flag, temperature control and offset trim register slice.
// Assumes an 8-bit register port with byte offsets from the block base.
package rftm_pkg;

   // ==========================================================================
   // Register offsets
   localparam logic [3:0] OFF_POWER_CONTROL   = 4'h0;
   localparam logic [3:0] OFF_RESET_CAUSE     = 4'h1;
   localparam logic [3:0] OFF_TEMP_CTRL_STAT  = 4'h2;
   localparam logic [3:0] OFF_TEMP_TRIM       = 4'h3;

   // ==========================================================================
   // Field positions
   localparam int GENERAL_WRITE_ENABLE_BIT    = 7;
   localparam int POWER_ON_RESET_FLAG_BIT     = 6;
   localparam int LOW_VOLTAGE_RESET_FLAG_BIT  = 5;
   localparam int SENSOR_OUTPUT_SELECT_BIT    = 4;
   localparam int TEMP_SENSOR_ENABLE_BIT      = 3;
   localparam int HIGH_TEMP_STATUS_BIT        = 2;
   localparam int HIGH_TEMP_IRQ_ENABLE_BIT    = 1;
   localparam int HIGH_TEMP_IRQ_FLAG_BIT      = 0;
   localparam int TEMP_OFFSET_TRIM_ENABLE_BIT = 7;
   localparam int TRIM_WIDTH                  = 4;

   // ==========================================================================
   // Reset values
   localparam logic [7:0] DATA_ZERO           = 8'h00;
   localparam logic [3:0] TRIM_POR_VALUE      = 4'h0;
   localparam logic       FLAG_AFTER_RESET    = 1'b1;

   // Output select encoding
   localparam logic SEL_TEMP_SENSOR           = 1'b0;
   localparam logic SEL_BANDGAP               = 1'b1;

   // ==========================================================================
   // Carriers
   typedef struct packed {
      logic [3:0] addr;
      logic       wr;
      logic [7:0] wdata;
   } rftm_bus_req_t;

   typedef struct packed {
      logic       clear_power_on_flag;
      logic       clear_low_voltage_flag;
      logic       trim_load;
      logic [3:0] trim_data;
   } rftm_sticky_cmd_t;

   typedef struct packed {
      logic       power_on_reset_flag;
      logic       low_voltage_reset_flag;
      logic [3:0] temp_offset_trim_value;
   } rftm_sticky_t;

endpackage

/* src/rftm_sticky_regs.sv */
// Reset-cause flags and offset trim value, which survive the system reset.
// Assumes POR_N and LVR_N are asynchronous, active-low, released synchronously.
`timescale 1ns/1ns
module rftm_sticky_regs (
   input  wire logic                      MCLK,
   input  wire logic                      POR_N,
   input  wire logic                      LVR_N,
   input  wire rftm_pkg::rftm_sticky_cmd_t CMD,
   output rftm_pkg::rftm_sticky_t          STICKY
);

   rftm_pkg::rftm_sticky_t st;
   rftm_pkg::rftm_sticky_t next_st;
   logic                   flag_rst_n;
   logic                   por_flag;
   logic                   lvr_flag;
   logic [3:0]             trim_value;

   // Both low-voltage and power-on resets preset the flags
   assign flag_rst_n = POR_N & LVR_N;

   always_comb begin
      next_st = st;
      if (CMD.clear_power_on_flag) begin
         next_st.power_on_reset_flag = 1'b0;
      end
      if (CMD.clear_low_voltage_flag) begin
         next_st.low_voltage_reset_flag = 1'b0;
      end
      if (CMD.trim_load) begin
         next_st.temp_offset_trim_value = CMD.trim_data;
      end
   end

   // ==========================================================================
   // Flags: untouched by system reset, set by power-on or low-voltage reset
   // Two reset domains, so the bits sit in separate flops, not one struct register
   always_ff @(posedge MCLK or negedge flag_rst_n) begin
      if (!flag_rst_n) begin
         por_flag <= rftm_pkg::FLAG_AFTER_RESET;
         lvr_flag <= rftm_pkg::FLAG_AFTER_RESET;
      end else begin
         por_flag <= next_st.power_on_reset_flag;
         lvr_flag <= next_st.low_voltage_reset_flag;
      end
   end

   // ==========================================================================
   // Trim: only a power-on reset clears it
   always_ff @(posedge MCLK or negedge POR_N) begin
      if (!POR_N) begin
         trim_value <= rftm_pkg::TRIM_POR_VALUE;
      end else begin
         trim_value <= next_st.temp_offset_trim_value;
      end
   end

   assign st     = {por_flag, lvr_flag, trim_value};
   assign STICKY = st;

endmodule // rftm_sticky_regs

/* src/rftm_regs.sv */
// Reset-flag, temperature control/status and temperature offset trim registers.
// Assumes all inputs synchronous to MCLK; POR_N/LVR_N reach only the sticky bits.
//
// Contract
// - Power-on reset sets flag; write-one clears
// - Low-voltage reset sets flag; write-one clears
// - System reset keeps flags; POR/LOW_VOLTAGE_RESET set both
// - Reserved bits read zero, writes ignored
// - Select bit routes sensor or bandgap output; code forces the sensor selection while bit 3 is clear
// - Bit 3 enables the temperature sensor
// - High-temperature status read-only, follows input
// - Status change sets flag; write-one clears
// - Flag and enable raise interrupt request
// - Trim applied only while trim enable set
// - Trim loaded from flash after system reset
// - Trim writes need general write enable
// - Only power-on reset clears trim value
// - Control bit 7 is general write enable
`timescale 1ns/1ns
module rftm_regs (
   input  wire logic       MCLK,
   input  wire logic       RESET_N,
   input  wire logic       POR_N,
   input  wire logic       LVR_N,
   input  wire logic [3:0] REG_ADDR,
   input  wire logic       REG_WR,
   input  wire logic [7:0] REG_WDATA,
   output logic      [7:0] REG_RDATA,
   input  wire logic       HIGH_TEMP,
   input  wire logic       FLASH_TRIM_VALID,
   input  wire logic [3:0] FLASH_TRIM,
   output logic            TEMP_SENSOR_ENABLE,
   output logic            SENSOR_OUTPUT_SELECT,
   output logic            TEMP_OFFSET_TRIM_ENABLE,
   output logic      [3:0] TEMP_OFFSET_TRIM,
   output logic            HIGH_TEMP_IRQ
);

   // ==========================================================================
   // State
   typedef struct packed {
      logic       general_write_enable;
      logic       sensor_output_select;
      logic       temp_sensor_enable;
      logic       high_temp_status;
      logic       high_temp_irq_enable;
      logic       high_temp_irq_flag;
      logic       temp_offset_trim_enable;
      logic       trim_load_pending;
      logic       irq;
      logic       sensor_en_out;
      logic       sensor_sel_out;
      logic       trim_en_out;
      logic [3:0] trim_out;
      logic [7:0] rdata;
   } rftm_state_t;

   rftm_state_t               st;
   rftm_state_t               next_st;
   rftm_pkg::rftm_bus_req_t   req;
   rftm_pkg::rftm_sticky_cmd_t cmd;
   rftm_pkg::rftm_sticky_t    sticky;
   logic [7:0]                rd_mux;
   logic                      wr_ctrl;
   logic                      wr_rst;
   logic                      wr_temp;
   logic                      wr_trim;

   assign req.addr  = REG_ADDR;
   assign req.wr    = REG_WR;
   assign req.wdata = REG_WDATA;

   assign wr_ctrl = req.wr && (req.addr == rftm_pkg::OFF_POWER_CONTROL);
   assign wr_rst  = req.wr && (req.addr == rftm_pkg::OFF_RESET_CAUSE);
   assign wr_temp = req.wr && (req.addr == rftm_pkg::OFF_TEMP_CTRL_STAT);
   // Protected: dropped silently while the general write enable is clear
   assign wr_trim = req.wr && (req.addr == rftm_pkg::OFF_TEMP_TRIM)
                    && st.general_write_enable;

   // ==========================================================================
   // Sticky commands
   always_comb begin
      cmd = '0;
      cmd.clear_power_on_flag    = wr_rst
         && req.wdata[rftm_pkg::POWER_ON_RESET_FLAG_BIT];
      cmd.clear_low_voltage_flag = wr_rst
         && req.wdata[rftm_pkg::LOW_VOLTAGE_RESET_FLAG_BIT];
      // Flash load has priority over a bus write in the same cycle
      if (st.trim_load_pending && FLASH_TRIM_VALID) begin
         cmd.trim_load = 1'b1;
         cmd.trim_data = FLASH_TRIM;
      end else if (wr_trim) begin
         cmd.trim_load = 1'b1;
         cmd.trim_data = req.wdata[rftm_pkg::TRIM_WIDTH-1:0];
      end
   end

   rftm_sticky_regs u_sticky (
      .MCLK   (MCLK),
      .POR_N  (POR_N),
      .LVR_N  (LVR_N),
      .CMD    (cmd),
      .STICKY (sticky)
   );

   // ==========================================================================
   // Read multiplexer; unmapped offsets and reserved bits read zero
   always_comb begin
      rd_mux = rftm_pkg::DATA_ZERO;
      unique case (req.addr)
         rftm_pkg::OFF_POWER_CONTROL: begin
            rd_mux[rftm_pkg::GENERAL_WRITE_ENABLE_BIT] = st.general_write_enable;
         end
         rftm_pkg::OFF_RESET_CAUSE: begin
            rd_mux[rftm_pkg::POWER_ON_RESET_FLAG_BIT]    = sticky.power_on_reset_flag;
            rd_mux[rftm_pkg::LOW_VOLTAGE_RESET_FLAG_BIT] = sticky.low_voltage_reset_flag;
         end
         rftm_pkg::OFF_TEMP_CTRL_STAT: begin
            rd_mux[rftm_pkg::SENSOR_OUTPUT_SELECT_BIT] = st.sensor_output_select;
            rd_mux[rftm_pkg::TEMP_SENSOR_ENABLE_BIT]   = st.temp_sensor_enable;
            rd_mux[rftm_pkg::HIGH_TEMP_STATUS_BIT]     = st.high_temp_status;
            rd_mux[rftm_pkg::HIGH_TEMP_IRQ_ENABLE_BIT] = st.high_temp_irq_enable;
            rd_mux[rftm_pkg::HIGH_TEMP_IRQ_FLAG_BIT]   = st.high_temp_irq_flag;
         end
         rftm_pkg::OFF_TEMP_TRIM: begin
            rd_mux[rftm_pkg::TEMP_OFFSET_TRIM_ENABLE_BIT] = st.temp_offset_trim_enable;
            rd_mux[rftm_pkg::TRIM_WIDTH-1:0] = sticky.temp_offset_trim_value;
         end
         default: begin
            rd_mux = rftm_pkg::DATA_ZERO;
         end
      endcase
   end

   // ==========================================================================
   // Next state
   always_comb begin
      next_st = st;
      next_st.rdata = rd_mux;

      if (wr_ctrl) begin
         next_st.general_write_enable =
            req.wdata[rftm_pkg::GENERAL_WRITE_ENABLE_BIT];
      end

      // Status bit ignores bus writes; it only tracks the comparator
      next_st.high_temp_status = HIGH_TEMP;

      if (wr_temp) begin
         next_st.sensor_output_select =
            req.wdata[rftm_pkg::SENSOR_OUTPUT_SELECT_BIT];
         next_st.temp_sensor_enable =
            req.wdata[rftm_pkg::TEMP_SENSOR_ENABLE_BIT];
         next_st.high_temp_irq_enable =
            req.wdata[rftm_pkg::HIGH_TEMP_IRQ_ENABLE_BIT];
         if (req.wdata[rftm_pkg::HIGH_TEMP_IRQ_FLAG_BIT]) begin
            next_st.high_temp_irq_flag = 1'b0;
         end
      end
      // A change in the clearing cycle still sets the flag
      if (HIGH_TEMP != st.high_temp_status) begin
         next_st.high_temp_irq_flag = 1'b1;
      end

      if (wr_trim) begin
         next_st.temp_offset_trim_enable =
            req.wdata[rftm_pkg::TEMP_OFFSET_TRIM_ENABLE_BIT];
      end
      if (st.trim_load_pending && FLASH_TRIM_VALID) begin
         next_st.trim_load_pending = 1'b0;
      end

      // Output stage, one cycle behind the registers
      next_st.irq = st.high_temp_irq_flag && st.high_temp_irq_enable;
      next_st.sensor_en_out = st.temp_sensor_enable;
      // Routing only means something while the sensor is on
      next_st.sensor_sel_out = st.temp_sensor_enable ? st.sensor_output_select
                                                     : rftm_pkg::SEL_TEMP_SENSOR;
      next_st.trim_en_out = st.temp_offset_trim_enable;
      next_st.trim_out = st.temp_offset_trim_enable ? sticky.temp_offset_trim_value
                                                    : rftm_pkg::TRIM_POR_VALUE;
   end

   // ==========================================================================
   // System-reset domain; the flash load is armed while RESET_N is low
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st <= '0;
         st.trim_load_pending <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign REG_RDATA               = st.rdata;
   assign HIGH_TEMP_IRQ           = st.irq;
   assign TEMP_SENSOR_ENABLE      = st.sensor_en_out;
   assign SENSOR_OUTPUT_SELECT    = st.sensor_sel_out;
   assign TEMP_OFFSET_TRIM_ENABLE = st.trim_en_out;
   assign TEMP_OFFSET_TRIM        = st.trim_out;

endmodule // rftm_regs

/* tb/rftm_regs_checker.sv */
// Port assertions for the reset-flag and temperature register slice.
// Assumes a bind into rftm_regs and resets held for several MCLK cycles.
`timescale 1ns/1ns
module rftm_regs_checker (
   input wire logic       MCLK,
   input wire logic       RESET_N,
   input wire logic [3:0] REG_ADDR,
   input wire logic       REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   input wire logic       HIGH_TEMP,
   input wire logic       TEMP_SENSOR_ENABLE,
   input wire logic       SENSOR_OUTPUT_SELECT,
   input wire logic       TEMP_OFFSET_TRIM_ENABLE,
   input wire logic [3:0] TEMP_OFFSET_TRIM,
   input wire logic       HIGH_TEMP_IRQ
);
   default clocking dc @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   // ==========================================================================
   // Control register accesses
   sequence ctrl_wr;
      REG_WR && REG_ADDR == 4'h2;
   endsequence
   // A status change in the clearing cycle wins, so it is left out
   sequence flag_ack;
      ctrl_wr ##0 REG_WDATA[0] && !$changed(HIGH_TEMP) && $past(RESET_N);
   endsequence
   flags_rsvd_a: assert property ($past(REG_ADDR) == 4'h1 |-> (REG_RDATA & 8'h9F) == 8'h00)
      else $error("Flag register spare bits set");
   ctrl_rsvd_a: assert property ($past(REG_ADDR) == 4'h2 |-> REG_RDATA[7:5] == 3'h0)
      else $error("Control register spare bits set");
   unmapped_rd_a: assert property ($past(REG_ADDR) > 4'h3 |-> REG_RDATA == 8'h00)
      else $error("Unmapped offset read nonzero");
   sens_en_a: assert property (ctrl_wr |-> ##2 TEMP_SENSOR_ENABLE == $past(REG_WDATA[3], 2))
      else $error("Sensor enable not following write");
   sel_gate_a: assert property (!TEMP_SENSOR_ENABLE |-> !SENSOR_OUTPUT_SELECT)
      else $error("Select active with sensor off");
   trim_gate_a: assert property (!TEMP_OFFSET_TRIM_ENABLE |-> TEMP_OFFSET_TRIM == 4'h0)
      else $error("Trim applied while disabled");
   irq_off_a: assert property (ctrl_wr ##0 !REG_WDATA[1] |-> ##2 !HIGH_TEMP_IRQ)
      else $error("Request with enable cleared");
   irq_clr_a: assert property (flag_ack |-> ##2 !HIGH_TEMP_IRQ)
      else $error("Request after flag clear");
endmodule // rftm_regs_checker

/* tb/rftm_regs_test.sv */
// Directed register bench for the reset-flag and temperature slice.
// Assumes rftm_regs and rftm_regs_checker are compiled before this file.
`timescale 1ns/1ns
module rftm_regs_test;
   logic       MCLK, RESET_N, POR_N, LVR_N, REG_WR, HIGH_TEMP, FLASH_TRIM_VALID;
   logic       TEMP_SENSOR_ENABLE, SENSOR_OUTPUT_SELECT, TEMP_OFFSET_TRIM_ENABLE, HIGH_TEMP_IRQ;
   logic [3:0] REG_ADDR, FLASH_TRIM, TEMP_OFFSET_TRIM;
   logic [7:0] REG_WDATA, REG_RDATA;
   int         err_total, samples_checked;
   rftm_regs dut_u (.MCLK(MCLK), .RESET_N(RESET_N), .POR_N(POR_N), .LVR_N(LVR_N),
      .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
      .HIGH_TEMP(HIGH_TEMP), .FLASH_TRIM_VALID(FLASH_TRIM_VALID), .FLASH_TRIM(FLASH_TRIM),
      .TEMP_SENSOR_ENABLE(TEMP_SENSOR_ENABLE), .SENSOR_OUTPUT_SELECT(SENSOR_OUTPUT_SELECT),
      .TEMP_OFFSET_TRIM_ENABLE(TEMP_OFFSET_TRIM_ENABLE), .TEMP_OFFSET_TRIM(TEMP_OFFSET_TRIM),
      .HIGH_TEMP_IRQ(HIGH_TEMP_IRQ));
   always #50 MCLK = ~MCLK;
   // ==========================================================================
   // Access tasks; inputs move 10 ns after the rising edge
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: saw %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge MCLK);
      #10;
   endtask
   // Idle cycle after a write so the strobe never toggles twice in one step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'b1;
      cyc(1);
      REG_WR = 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      REG_ADDR = a;
      cyc(1);
      chk(REG_RDATA, exp);
   endtask
   task automatic rst(input logic [2:0] m);
      {POR_N, LVR_N, RESET_N} = m;
      cyc(12);
      {POR_N, LVR_N, RESET_N} = 3'b111;
      cyc(1);
   endtask
   task automatic end_sim;
      $display("Compared %0d, mismatched %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge MCLK);
      err_total++;
      end_sim;
   end
   initial begin
      MCLK = 1'b0;
      err_total = 0;
      samples_checked = 0;
      {REG_WR, HIGH_TEMP, FLASH_TRIM_VALID} = 3'h0;
      REG_ADDR = 4'h0;
      REG_WDATA = 8'h00;
      FLASH_TRIM = 4'h9;
      rst(3'b000);
      rd(4'h3, 8'h00);
      rd(4'h1, 8'h60);
      FLASH_TRIM_VALID = 1'b1;
      cyc(1);
      rd(4'h3, 8'h09);
      wr(4'h1, 8'hC0);
      rd(4'h1, 8'h20);
      FLASH_TRIM = 4'h3;
      rst(3'b101);
      rd(4'h1, 8'h60);
      rd(4'h3, 8'h09);
      rst(3'b110);
      rd(4'h1, 8'h60);
      rd(4'h3, 8'h03);
      wr(4'h1, 8'h60);
      rd(4'h1, 8'h00);
      wr(4'h3, 8'h8C);
      rd(4'h3, 8'h03);
      chk(TEMP_OFFSET_TRIM, 8'h00);
      rd(4'h9, 8'h00);
      wr(4'h0, 8'h80);
      wr(4'h3, 8'hF5);
      rd(4'h3, 8'h85);
      chk(TEMP_OFFSET_TRIM, 8'h05);
      chk(TEMP_OFFSET_TRIM_ENABLE, 8'h01);
      wr(4'h2, 8'hFF);
      rd(4'h2, 8'h1A);
      chk(SENSOR_OUTPUT_SELECT, 8'h01);
      chk(TEMP_SENSOR_ENABLE, 8'h01);
      wr(4'h2, 8'h0A);
      chk(SENSOR_OUTPUT_SELECT, 8'h00);
      HIGH_TEMP = 1'b1;
      cyc(2);
      chk(HIGH_TEMP_IRQ, 8'h01);
      rd(4'h2, 8'h0F);
      wr(4'h2, 8'h08);
      chk(HIGH_TEMP_IRQ, 8'h00);
      rd(4'h2, 8'h0D);
      wr(4'h2, 8'h0B);
      rd(4'h2, 8'h0E);
      chk(HIGH_TEMP_IRQ, 8'h00);
      HIGH_TEMP = 1'b0;
      cyc(2);
      chk(HIGH_TEMP_IRQ, 8'h01);
      wr(4'h2, 8'h01);
      rd(4'h2, 8'h00);
      // Status change in the clearing cycle: the set wins
      HIGH_TEMP = 1'b1;
      wr(4'h2, 8'h01);
      rd(4'h2, 8'h05);
      // Select stored as bandgap while the sensor is off
      wr(4'h2, 8'h10);
      rd(4'h2, 8'h15);
      chk(SENSOR_OUTPUT_SELECT, 8'h00);
      chk(TEMP_SENSOR_ENABLE, 8'h00);
      end_sim;
   end
endmodule // rftm_regs_test
bind rftm_regs rftm_regs_checker chk_u (.MCLK(MCLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
   .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .HIGH_TEMP(HIGH_TEMP),
   .TEMP_SENSOR_ENABLE(TEMP_SENSOR_ENABLE), .SENSOR_OUTPUT_SELECT(SENSOR_OUTPUT_SELECT),
   .TEMP_OFFSET_TRIM_ENABLE(TEMP_OFFSET_TRIM_ENABLE), .TEMP_OFFSET_TRIM(TEMP_OFFSET_TRIM),
   .HIGH_TEMP_IRQ(HIGH_TEMP_IRQ));
